// ===== src/rie_decode_exec.sv
// decode and execute unit for 14-bit instruction words, 8-bit accumulator
// assumes a program memory answering o_pm_addr within one oscillator cycle
// and a file space answering o_file_req.addr within two oscillator cycles
//
// Behaviour
// - xor with file updates zero only
// - destination bit selects accumulator or file
// - bit clear zeroes chosen bit, flags kept
// - bit set forces chosen bit, flags kept
// - skip if zero: one cycle, two if skipped
// - skip if one: one cycle, two if skipped
// - add literal updates carry, digit carry, zero
// - and/or literal update zero flag only
// - return with literal loads accumulator, two cycles
// - plain return pops stack, two cycles
// - interrupt return pops stack, two cycles
// - watchdog clear sets timeout and powerdown
// - standby sets timeout, clears powerdown
// - literal minus accumulator updates carry, digit, zero
// - port read as source uses pin levels
// - timer count write clears assigned prescaler
// - branch or true test adds nop cycle
// - instruction cycle spans four oscillator periods
// - named file register always read first
// - file address covers 128 locations
`timescale 1ns/10ps

module rie_decode_exec
  import rie_pkg::*;
#(
  parameter int unsigned PORT_W = 8,
  parameter int unsigned STACK_N = STACK_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [INSTR_W-1:0] i_pm_data,
  input wire logic [DATA_W-1:0] i_file_rdata,
  input wire logic [PORT_W-1:0] i_port_pins,
  input wire logic [1:0] i_page_sel,
  input wire logic i_prescale_to_timer,
  input wire logic i_wake,
  output logic [PC_W-1:0] o_pm_addr,
  output rie_file_req_t o_file_req,
  output logic o_file_rd,
  output logic o_file_wr,
  output logic [DATA_W-1:0] o_acc,
  output rie_status_t o_status,
  output logic o_prescaler_clr,
  output logic o_wdt_clr,
  output logic o_standby,
  output logic o_irq_return,
  output logic o_cycle_end
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rie_state_t state_r, state_nxt;
  logic [INSTR_W-1:0] ir_r;
  logic [DATA_W-1:0] src_r;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  rie_status_t status_r, status_nxt;
  logic flush_r;
  logic [PC_W-1:0] stack_mem [STACK_N];
  logic [$clog2(STACK_N)-1:0] sp_r;
  logic [2:0] pin_sync_r [PORT_W];
  logic [PORT_W-1:0] pin_val_r;
  logic [2:0] wake_sync_r;
  logic wake_val_r;

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  wire [1:0] pfx = ir_r[13:12];
  wire [3:0] op4 = ir_r[11:8];
  wire [1:0] bop = ir_r[11:10];
  wire [2:0] bsel = ir_r[9:7];
  wire dest = ir_r[7];
  wire [FADDR_W-1:0] faddr = ir_r[6:0];
  wire [DATA_W-1:0] lit = ir_r[7:0];
  wire [JUMP_W-1:0] target = ir_r[10:0];
  wire is_byte = (pfx == PFX_BYTE);
  wire is_bit = (pfx == PFX_BIT);
  wire is_lit = (pfx == PFX_LIT);
  wire is_swap = is_byte && (op4 == OP_SWAP);
  wire is_xor = is_byte && (op4 == OP_XOR);
  wire is_add = is_byte && (op4 == OP_ADD);
  wire is_bclr = is_bit && (bop == OP_BCLR);
  wire is_bset = is_bit && (bop == OP_BSET);
  wire is_tskz = is_bit && (bop == OP_TSKZ);
  wire is_tsko = is_bit && (bop == OP_TSKO);
  wire is_addlit = is_lit && (op4[3:1] == OP_ADDLIT);
  wire is_andlit = is_lit && (op4 == OP_ANDLIT);
  wire is_orlit = is_lit && (op4 == OP_ORLIT);
  wire is_loadlit = is_lit && (op4[3:2] == OP_LOADLIT);
  wire is_retlit = is_lit && (op4[3:2] == OP_RETLIT);
  wire is_sublit = is_lit && (op4[3:1] == OP_SUBLIT);
  wire is_call = (pfx == PFX_JUMP) && !ir_r[11];
  wire is_goto = (pfx == PFX_JUMP) && ir_r[11];
  wire is_ret = (ir_r == WORD_RETURN);
  wire is_reti = (ir_r == WORD_RETURN_IRQ);
  wire is_wdtc = (ir_r == WORD_WDT_CLEAR);
  wire is_stby = (ir_r == WORD_STANDBY);
  wire is_pop = is_ret || is_reti || is_retlit;
  wire is_file_op = is_swap || is_xor || is_add || is_bit;

  // executing word; a flushed cycle behaves as a nop
  wire live = !flush_r;
  wire [1:0] nx_pfx = i_pm_data[13:12];
  wire [3:0] nx_op4 = i_pm_data[11:8];
  wire nx_file_op = (nx_pfx == PFX_BIT) || ((nx_pfx == PFX_BYTE)
                    && (nx_op4 == OP_SWAP || nx_op4 == OP_XOR || nx_op4 == OP_ADD));

  // ----------------------------------------------------------------------
  // source select: a port read sees the pins, not the latch
  // ----------------------------------------------------------------------
  wire src_is_port = (faddr == PORT_ADDR);
  wire [DATA_W-1:0] pin_byte = DATA_W'(pin_val_r);
  wire [DATA_W-1:0] src_sel = src_is_port ? pin_byte : i_file_rdata;

  // ----------------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------------
  wire [DATA_W-1:0] add_b = is_add ? src_r : lit;
  wire [DATA_W:0] add_sum = {1'b0, acc_r} + {1'b0, add_b};
  wire [4:0] add_low = {1'b0, acc_r[3:0]} + {1'b0, add_b[3:0]};
  wire [DATA_W-1:0] acc_inv = ~acc_r;
  // two's complement subtract: carry out set means no borrow
  wire [DATA_W:0] sub_sum = {1'b0, lit} + {1'b0, acc_inv} + 9'h001;
  wire [4:0] sub_low = {1'b0, lit[3:0]} + {1'b0, acc_inv[3:0]} + 5'h01;
  wire [DATA_W-1:0] bit_mask = 8'h01 << bsel;
  wire bit_val = |(src_r & bit_mask);
  wire [DATA_W-1:0] swap_val = {src_r[3:0], src_r[7:4]};

  logic [DATA_W-1:0] res;
  logic upd_z, upd_c;
  logic c_val, dc_val;
  always_comb begin
    res = acc_r;
    upd_z = 1'b0;
    upd_c = 1'b0;
    c_val = status_r.carry;
    dc_val = status_r.digit_carry_flag;
    if (is_swap) begin
      res = swap_val;
    end else if (is_xor) begin
      res = acc_r ^ src_r;
      upd_z = 1'b1;
    end else if (is_add || is_addlit) begin
      res = add_sum[DATA_W-1:0];
      upd_z = 1'b1;
      upd_c = 1'b1;
      c_val = add_sum[DATA_W];
      dc_val = add_low[4];
    end else if (is_sublit) begin
      res = sub_sum[DATA_W-1:0];
      upd_z = 1'b1;
      upd_c = 1'b1;
      c_val = sub_sum[DATA_W];
      dc_val = sub_low[4];
    end else if (is_bclr) begin
      res = src_r & ~bit_mask;
    end else if (is_bset) begin
      res = src_r | bit_mask;
    end else if (is_andlit) begin
      res = acc_r & lit;
      upd_z = 1'b1;
    end else if (is_orlit) begin
      res = acc_r | lit;
      upd_z = 1'b1;
    end else if (is_loadlit || is_retlit) begin
      res = lit;
    end
  end

  // ----------------------------------------------------------------------
  // destination and side effects
  // ----------------------------------------------------------------------
  wire byte_dest_file = (is_swap || is_xor || is_add) && (dest == DEST_FILE);
  wire wr_file = live && (byte_dest_file || is_bclr || is_bset);
  wire wr_acc = live && (((is_swap || is_xor || is_add) && (dest != DEST_FILE))
                || is_addlit || is_sublit || is_andlit || is_orlit || is_loadlit
                || is_retlit);
  wire tmr_write = wr_file && (faddr == TIMER_ZERO_ADDR) && i_prescale_to_timer;
  wire skip = live && ((is_tskz && !bit_val) || (is_tsko && bit_val));
  wire branch = live && (is_call || is_goto || is_pop);
  wire [PC_W-1:0] pc_inc = pc_r + 13'h0001;
  wire [PC_W-1:0] pc_jump = {i_page_sel, target};
  wire [$clog2(STACK_N)-1:0] sp_dec = sp_r - 1'b1;

  assign pc_nxt = !live ? pc_r
                : (is_call || is_goto) ? pc_jump
                : is_pop ? stack_mem[sp_dec]
                : skip ? pc_r + 13'h0002 : pc_inc;

  always_comb begin
    acc_nxt = wr_acc ? res : acc_r;
    status_nxt = status_r;
    if (live && upd_z) begin
      status_nxt.zero = (res == 8'h00);
    end
    if (live && upd_c) begin
      status_nxt.carry = c_val;
      status_nxt.digit_carry_flag = dc_val;
    end
    if (live && is_wdtc) begin
      status_nxt.timeout_flag = 1'b1;
      status_nxt.powerdown_flag = 1'b1;
    end
    if (live && is_stby) begin
      status_nxt.timeout_flag = 1'b1;
      status_nxt.powerdown_flag = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // phase sequencer: four oscillator periods per instruction cycle
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_Q1: state_nxt = ST_Q2;
      ST_Q2: state_nxt = ST_Q3;
      ST_Q3: state_nxt = ST_Q4;
      ST_Q4: state_nxt = (live && is_stby) ? ST_STBY : ST_Q1;
      ST_STBY: state_nxt = wake_val_r ? ST_Q1 : ST_STBY;
      default: state_nxt = ST_Q1;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= ST_Q1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // input synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          pin_sync_r[gi] <= 3'h0;
          pin_val_r[gi] <= 1'b0;
        end else begin
          pin_sync_r[gi] <= {pin_sync_r[gi][1:0], i_port_pins[gi]};
          if (pin_sync_r[gi][1] == pin_sync_r[gi][2]) begin
            pin_val_r[gi] <= pin_sync_r[gi][2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wake_sync_r <= 3'h0;
      wake_val_r <= 1'b0;
    end else begin
      wake_sync_r <= {wake_sync_r[1:0], i_wake};
      if (wake_sync_r[1] == wake_sync_r[2]) begin
        wake_val_r <= wake_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // datapath registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ir_r <= 14'h0000;
      src_r <= 8'h00;
      o_file_req <= '0;
      o_file_rd <= 1'b0;
    end else begin
      o_file_rd <= 1'b0;
      if (state_r == ST_Q1) begin
        ir_r <= i_pm_data;
        o_file_req.addr <= i_pm_data[6:0];
        // read even for write-only ops so side effects match
        o_file_rd <= !flush_r && nx_file_op;
      end
      if (state_r == ST_Q3) begin
        src_r <= src_sel;
      end
      if (state_r == ST_Q4) begin
        o_file_req.data <= res;
      end
    end
  end

  // Q4 commits; writes and pulses leave during the following Q1, or during the first standby clock after a standby word
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pc_r <= PC_RESET;
      acc_r <= ACC_RESET;
      status_r <= STATUS_RESET;
      flush_r <= 1'b0;
      sp_r <= '0;
      o_file_wr <= 1'b0;
      o_prescaler_clr <= 1'b0;
      o_wdt_clr <= 1'b0;
      o_irq_return <= 1'b0;
      o_cycle_end <= 1'b0;
    end else begin
      o_file_wr <= 1'b0;
      o_prescaler_clr <= 1'b0;
      o_wdt_clr <= 1'b0;
      o_irq_return <= 1'b0;
      o_cycle_end <= 1'b0;
      if (state_r == ST_Q4) begin
        pc_r <= pc_nxt;
        acc_r <= acc_nxt;
        status_r <= status_nxt;
        flush_r <= skip || branch;
        o_file_wr <= wr_file && is_file_op;
        o_prescaler_clr <= tmr_write;
        o_wdt_clr <= live && (is_wdtc || is_stby);
        o_irq_return <= live && is_reti;
        o_cycle_end <= 1'b1;
        if (live && is_call) begin
          sp_r <= sp_r + 1'b1;
        end else if (live && is_pop) begin
          sp_r <= sp_dec;
        end
      end
    end
  end

  // return stack wraps around; overflow silently overwrites the oldest
  always_ff @(posedge i_ref_clk) begin
    if ((state_r == ST_Q4) && live && is_call) begin
      stack_mem[sp_r] <= pc_inc;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pm_addr <= PC_RESET;
      o_acc <= ACC_RESET;
      o_status <= STATUS_RESET;
      o_standby <= 1'b0;
    end else begin
      o_pm_addr <= (state_r == ST_Q4) ? pc_nxt : pc_r;
      o_acc <= (state_r == ST_Q4) ? acc_nxt : acc_r;
      o_status <= (state_r == ST_Q4) ? status_nxt : status_r;
      o_standby <= (state_nxt == ST_STBY);
    end
  end

endmodule : rie_decode_exec

// ===== src/rie_pkg.sv
// opcode encodings, state codes, flag layout and fixed addresses for the
// 14-bit instruction decode and execute unit
// assumes one oscillator clock and a file space outside the unit
package rie_pkg;

  // ----------------------------------------------------------------------
  // word layout and fixed words
  // ----------------------------------------------------------------------
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 13;
  localparam int unsigned JUMP_W = 11;
  localparam logic [13:0] WORD_RETURN = 14'h0008;
  localparam logic [13:0] WORD_RETURN_IRQ = 14'h0009;
  localparam logic [13:0] WORD_WDT_CLEAR = 14'h0064;
  localparam logic [13:0] WORD_STANDBY = 14'h0063;

  // ----------------------------------------------------------------------
  // opcode prefixes and fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] PFX_BYTE = 2'h0;
  localparam logic [1:0] PFX_BIT = 2'h1;
  localparam logic [1:0] PFX_JUMP = 2'h2;
  localparam logic [1:0] PFX_LIT = 2'h3;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [1:0] OP_BCLR = 2'h0;
  localparam logic [1:0] OP_BSET = 2'h1;
  localparam logic [1:0] OP_TSKZ = 2'h2;
  localparam logic [1:0] OP_TSKO = 2'h3;
  localparam logic [2:0] OP_ADDLIT = 3'h7;
  localparam logic [3:0] OP_ANDLIT = 4'h9;
  localparam logic [3:0] OP_ORLIT = 4'h8;
  localparam logic [1:0] OP_LOADLIT = 2'h0;
  localparam logic [1:0] OP_RETLIT = 2'h1;
  localparam logic [2:0] OP_SUBLIT = 3'h6;
  localparam logic DEST_FILE = 1'b1;

  // ----------------------------------------------------------------------
  // fixed file addresses, reset values, timing
  // ----------------------------------------------------------------------
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_ADDR = 7'h05;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam int unsigned OSC_PER_CYCLE = 4;
  localparam int unsigned STACK_DEPTH = 8;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_Q1 = 5'b00001,
    ST_Q2 = 5'b00010,
    ST_Q3 = 5'b00100,
    ST_Q4 = 5'b01000,
    ST_STBY = 5'b10000
  } rie_state_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } rie_status_t;

  localparam rie_status_t STATUS_RESET = 5'b11000;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } rie_file_req_t;

endpackage : rie_pkg

// ===== testbench/rie_decode_exec_asserts.sv
// concurrent checks on the decode and execute unit ports
// assumes one clock domain and the synchronous high reset
`timescale 1ns/10ps

module rie_decode_exec_asserts
  import rie_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [PC_W-1:0] o_pm_addr,
  input wire rie_file_req_t o_file_req,
  input wire logic o_file_rd,
  input wire logic o_file_wr,
  input wire logic [DATA_W-1:0] o_acc,
  input wire rie_status_t o_status,
  input wire logic o_prescaler_clr,
  input wire logic o_wdt_clr,
  input wire logic o_standby,
  input wire logic o_irq_return,
  input wire logic o_cycle_end
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence s_no_end3;
    !o_cycle_end [*3];
  endsequence
  sequence s_no_rd3;
    !o_file_rd [*3];
  endsequence
  a_cycle_four: assert property (o_cycle_end |=> s_no_end3)
    else $error("cycle end spacing below four clocks");
  a_read_first: assert property (o_file_wr |-> $past(o_file_rd, 3))
    else $error("file write without read three clocks before");
  a_wr_at_end: assert property (o_file_wr |-> o_cycle_end)
    else $error("file write outside cycle end");
  a_presc_timer: assert property (o_prescaler_clr |->
    o_file_wr && o_file_req.addr == TIMER_ZERO_ADDR)
    else $error("prescaler clear without timer write");
  a_acc_commit: assert property (!$stable(o_acc) |-> o_cycle_end)
    else $error("accumulator moved mid cycle");
  a_pc_commit: assert property (!$stable(o_pm_addr) |-> o_cycle_end)
    else $error("program address moved mid cycle");
  a_wdt_timeout: assert property (o_wdt_clr |->
    o_status.timeout_flag && (o_status.powerdown_flag != o_standby))
    else $error("timeout flag not set by watchdog clear");
  a_sleep_pd: assert property ($rose(o_standby) |->
    ##[0:1] !o_status.powerdown_flag)
    else $error("powerdown flag not cleared by standby");
  a_irq_end: assert property (o_irq_return |-> o_cycle_end)
    else $error("interrupt return outside cycle end");
  a_rd_pulse: assert property (o_file_rd |=> s_no_rd3)
    else $error("more than one file read per cycle");
endmodule : rie_decode_exec_asserts

bind rie_decode_exec rie_decode_exec_asserts u_chk (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .o_pm_addr(o_pm_addr), .o_file_req(o_file_req),
  .o_file_rd(o_file_rd), .o_file_wr(o_file_wr), .o_acc(o_acc), .o_status(o_status),
  .o_prescaler_clr(o_prescaler_clr), .o_wdt_clr(o_wdt_clr), .o_standby(o_standby),
  .o_irq_return(o_irq_return), .o_cycle_end(o_cycle_end));

// ===== testbench/rie_mem_model.sv
// program memory and file space model facing the unit
// assumes the bench loads rom and ram by hierarchical reference
`timescale 1ns/10ps

module rie_mem_model
  import rie_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [PC_W-1:0] i_pm_addr,
  input wire rie_file_req_t i_file_req,
  input wire logic i_file_rd,
  input wire logic i_file_wr,
  output logic [INSTR_W-1:0] o_pm_data,
  output logic [DATA_W-1:0] o_file_rdata
);
  logic [INSTR_W-1:0] rom [0:63];
  logic [DATA_W-1:0] ram [0:127];
  logic rd_d1_r;
  logic rd_d2_r;
  wire logic rd_win = i_file_rd | rd_d1_r | rd_d2_r;
  assign o_pm_data = rom[i_pm_addr[5:0]];
  // outside the read window the bus shows the inverse, never a stale match
  assign o_file_rdata = rd_win ? ram[i_file_req.addr] : ~ram[i_file_req.addr];
  always_ff @(posedge i_ref_clk) begin
    rd_d1_r <= i_file_rd;
    rd_d2_r <= rd_d1_r;
    if (i_file_wr === 1'b1) begin
      ram[i_file_req.addr] <= i_file_req.data;
    end
  end
endmodule : rie_mem_model

// ===== testbench/tb.sv
// self-checking bench for the decode and execute unit
// assumes the memory model and the bound checker
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb;
  import rie_pkg::*;
  logic i_ref_clk = 0, i_reset = 1, i_prescale_to_timer = 0, i_wake = 0;
  logic [7:0] i_port_pins = 8'h00;
  logic [1:0] i_page_sel = 2'h0;
  logic [13:0] pm_data;
  logic [7:0] rdata, a, k, v, e;
  logic [PC_W-1:0] pm_addr;
  rie_file_req_t file_req;
  logic file_rd, file_wr, presc, wdt, stby, irq, cend;
  logic [7:0] acc;
  rie_status_t st;
  wire [10:0] lit_got = {acc, st.zero, st.digit_carry_flag, st.carry};
  logic [31:0] rnd = 32'h46c4f298;
  logic [6:0] f;
  logic [2:0] b, c;
  int num_errors = 0, checked = 0, n_pre, n_wdt, n_irq;

  always #5 i_ref_clk = ~i_ref_clk;
  rie_decode_exec u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_pm_data(pm_data),
    .i_file_rdata(rdata), .i_port_pins(i_port_pins), .i_page_sel(i_page_sel),
    .i_prescale_to_timer(i_prescale_to_timer), .i_wake(i_wake), .o_pm_addr(pm_addr),
    .o_file_req(file_req), .o_file_rd(file_rd), .o_file_wr(file_wr), .o_acc(acc),
    .o_status(st), .o_prescaler_clr(presc), .o_wdt_clr(wdt), .o_standby(stby),
    .o_irq_return(irq), .o_cycle_end(cend));
  rie_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_pm_addr(pm_addr), .i_file_req(file_req),
    .i_file_rd(file_rd), .i_file_wr(file_wr), .o_pm_data(pm_data), .o_file_rdata(rdata));

  always @(posedge i_ref_clk) begin
    n_pre += (presc === 1'b1);
    n_wdt += (wdt === 1'b1);
    n_irq += (irq === 1'b1);
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rand8();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction : rand8
  function automatic logic [7:0] swp(input logic [7:0] x);
    return {x[3:0], x[7:4]};
  endfunction : swp
  // returns {acc, zero, digit carry, carry}; and/or leave the reset carries
  function automatic logic [10:0] lit_exp(input int op, input logic [7:0] a, k);
    logic [8:0] s;
    logic dc;
    logic cy;
    s = {1'b0, a} + k;
    dc = ({1'b0, a[3:0]} + k[3:0]) > 5'h0f;
    cy = s[8];
    if (op == 1) begin
      s = {1'b0, k} - a;
      dc = k[3:0] >= a[3:0];
      cy = k >= a;
    end
    if (op >= 2) begin
      s = (op == 2) ? {1'b0, a & k} : {1'b0, a | k};
      dc = 1'b0;
      cy = 1'b0;
    end
    return {s[7:0], s[7:0] == 8'h00, dc, cy};
  endfunction : lit_exp

  task automatic restart();
    i_reset = 1;
    for (int i = 0; i < 64; i++) u_mem.rom[i] = 14'h0000;
    n_pre = 0;
    n_wdt = 0;
    n_irq = 0;
    repeat (12) @(negedge i_ref_clk);
  endtask : restart
  task automatic run(input int n);
    int t;
    i_reset = 0;
    for (int i = 0; i < n; i++) begin
      t = 0;
      // cycle end stands one clock; look at it between edges
      @(negedge i_ref_clk);
      while (cend !== 1'b1 && t < 40) begin
        @(negedge i_ref_clk);
        t++;
      end
      if (t >= 40) num_errors++;
    end
    @(negedge i_ref_clk);
  endtask : run
  task automatic final_report();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  initial begin
    #400000;
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    logic [3:0] opn [4] = '{4'he, 4'hc, 4'h9, 4'h8};
    for (int i = 0; i < 8; i++) begin
      restart();
      a = (i == 0) ? 8'hff : rand8();
      k = (i == 0) ? 8'h01 : rand8();
      u_mem.rom[0] = {2'b11, 4'h0, a};
      u_mem.rom[1] = {2'b11, opn[i % 4] | (i[2] ? 4'h1 : 4'h0) & {4{i % 4 < 2}}, k};
      run(2);
      `CHK("lit acc", lit_exp(i % 4, a, k), lit_got)
    end
    $display("literal test done");
    for (int i = 0; i < 4; i++) begin
      restart();
      a = rand8();
      v = rand8();
      f = (i == 0) ? 7'h7f : 7'(rand8()) | 7'h08;
      b = 3'(rand8());
      c = 3'(rand8());
      k = (i == 0) ? swp(a ^ v) : rand8();
      i_port_pins = rand8();
      i_prescale_to_timer = i[0];
      u_mem.ram[f] = v;
      u_mem.ram[TIMER_ZERO_ADDR] = k;
      u_mem.rom[0] = {2'b11, 4'h0, a};
      u_mem.rom[1] = {2'b00, 4'h6, 1'b1, f};
      u_mem.rom[2] = {2'b00, 4'he, 1'b0, f};
      u_mem.rom[3] = {2'b01, 2'h1, b, f};
      u_mem.rom[4] = {2'b01, 2'h0, c, f};
      u_mem.rom[5] = {2'b00, 4'he, 1'b1, PORT_ADDR};
      u_mem.rom[6] = {2'b00, 4'h6, 1'b1, TIMER_ZERO_ADDR};
      run(7);
      e = (a ^ v | 8'h01 << b) & ~(8'h01 << c);
      `CHK("file acc", swp(a ^ v), acc)
      `CHK("file reg", e, u_mem.ram[f])
      `CHK("port reg", swp(i_port_pins), u_mem.ram[PORT_ADDR])
      `CHK("zero", (swp(a ^ v) ^ k) == 8'h00, st.zero)
      `CHK("timer reg", swp(a ^ v) ^ k, u_mem.ram[TIMER_ZERO_ADDR])
      `CHK("prescaler", int'(i_prescale_to_timer), n_pre)
    end
    $display("file test done");
    restart();
    i_page_sel = 2'h1;
    f = 7'h20;
    b = rand8();
    u_mem.ram[f] = rand8() & ~(8'h01 << b);
    u_mem.rom[0] = {2'b01, 2'h2, b, f};
    u_mem.rom[1] = {2'b11, 4'h0, 8'h11};
    u_mem.rom[2] = {2'b01, 2'h3, b, f};
    u_mem.rom[3] = {2'b11, 4'h0, 8'h22};
    u_mem.rom[4] = {2'b10, 1'b0, 11'd10};
    u_mem.rom[5] = {2'b10, 1'b0, 11'd12};
    u_mem.rom[6] = {2'b10, 1'b0, 11'd14};
    u_mem.rom[7] = WORD_WDT_CLEAR;
    u_mem.rom[8] = WORD_STANDBY;
    u_mem.rom[9] = {2'b10, 1'b1, 11'd16};
    u_mem.rom[16] = {2'b10, 1'b1, 11'd16};
    u_mem.rom[10] = {2'b11, 4'h4, 8'h33};
    u_mem.rom[12] = WORD_RETURN;
    u_mem.rom[14] = WORD_RETURN_IRQ;
    run(4);
    `CHK("skip acc", 8'h22, acc)
    run(4);
    `CHK("retlit acc", 8'h33, acc)
    `CHK("retlit pc", 13'd5, pm_addr)
    run(9);
    `CHK("ret pc", 13'd8, pm_addr)
    `CHK("irq ret", 1, n_irq)
    `CHK("wdt flags", 2'b11, {st.timeout_flag, st.powerdown_flag})
    run(1);
    repeat (2) @(negedge i_ref_clk);
    `CHK("standby", 1'b1, stby)
    `CHK("sleep flags", 2'b10, {st.timeout_flag, st.powerdown_flag})
    `CHK("wdt count", 2, n_wdt)
    i_wake = 1;
    repeat (20) @(negedge i_ref_clk);
    `CHK("woken", 1'b0, stby)
    `CHK("jump pc", {2'h1, 11'd16}, pm_addr)
    $display("control test done");
    final_report();
  end
endmodule : tb
